// [hdl/air_frame_keystream_xor.sv]
// Purpose: Bit-serial keystream XOR over one 388-bit slot field
// Assumes: Field bits arrive in air order; keystream bits in generator order
// Notes:   Redundancy checks are produced and checked outside this block
`timescale 1ns/1ps
`include "air_frame_keystream_xor_params.svh"

module air_frame_keystream_xor (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  // Slot control from the framing logic
  input  wire logic                                slotStart,
  input  wire logic                                cipherOn,
  input  wire air_frame_keystream_xor_pkg::tail_t  tailType,
  input  wire logic                                protFmt,
  input  wire logic                                frameStart,
  // Field bits in
  input  wire logic                                inValid,
  input  wire logic                                inBit,
  output logic                                     inReady,
  // Keystream bits from the generator
  input  wire logic                                ksValid,
  input  wire logic                                ksBit,
  output logic                                     ksReady,
  // Field bits out
  output logic                                     outValid,
  output logic                                     outBit,
  input  wire logic                                outReady,
  // Status
  output logic                                     fieldBusy,
  output logic                                     segSecond
);

  // Walker state
  air_frame_keystream_xor_pkg::walk_t state_r;    // Idle or inside a field
  air_frame_keystream_xor_pkg::walk_t state_nxt;
  logic [8:0]  pos_r;                             // Bit position in field
  logic [8:0]  pos_nxt;
  logic [6:0]  sub_r;                             // Offset in protected subblock
  logic        encOn_r;                           // Cipher active for this field
  logic        ctlTail_r;                         // Tail is of control type
  logic        prot_r;                            // Protected B-field format
  logic        encOn_nxt;

  // Keystream holding stage
  logic        ksHeld_r;                          // One keystream bit waiting
  logic        ksHold_r;                          // The waiting keystream bit
  logic        ksHeld_nxt;
  logic [8:0]  segIdx_r;                          // Segment bit index consumed
  logic        segSecond_r;                       // Second segment of the pair

  // Two-entry output buffer: head drives the port, skid catches stalls
  logic        headV_r;
  logic        headB_r;
  logic        skidV_r;
  logic        skidB_r;
  logic        headV_nxt;
  logic        headB_nxt;
  logic        skidV_nxt;
  logic        skidB_nxt;

  // Registered handshakes
  logic        inReady_r;
  logic        ksReady_r;
  logic        fieldBusy_r;

  // Per-bit decisions
  logic        push;                              // Field bit accepted
  logic        pop;                               // Output bit taken
  logic        ksTake;                            // Keystream bit accepted
  logic        inTail;                            // Current bit is tail a8-a47
  logic        inBData;                           // Current bit is B data 0-319
  logic        need;                              // Current bit uses keystream
  logic        needNxt;                           // Next bit uses keystream
  logic        xorEn;                             // Current bit gets XOR
  logic        dataOut;                           // Bit after the cipher

  // Position classes; header, A check and B check never match here
  function automatic logic isTail(input logic [8:0] p);
    isTail = (p >= `TAIL_FIRST) && (p <= `TAIL_LAST);
  endfunction : isTail

  function automatic logic isBData(input logic [8:0] p);
    isBData = (p >= `B_FIRST) && (p <= `B_DATA_LAST);
  endfunction : isBData

  // Handshake events
  assign push   = inValid && inReady_r;
  assign pop    = headV_r && outReady;
  assign ksTake = ksValid && ksReady_r;

  // Classify the bit being accepted now
  assign inTail  = (state_r == air_frame_keystream_xor_pkg::ST_FIELD) && isTail(pos_r);
  assign inBData = (state_r == air_frame_keystream_xor_pkg::ST_FIELD) && isBData(pos_r);

  // Every tail and B data position eats one keystream bit, used or dropped,
  // so the B mapping always starts at segment bit 40
  assign need = encOn_r && (inTail || inBData);

  // XOR only control tails and B data outside subblock checks
  always_comb begin
    xorEn = 1'b0;
    if (encOn_r && inTail && ctlTail_r) begin
      xorEn = 1'b1;
    end else if (encOn_r && inBData && !prot_r) begin
      xorEn = 1'b1;
    end else if (encOn_r && inBData && prot_r && (sub_r < `SUB_DATA)) begin
      xorEn = 1'b1;
    end
  end

  // One XOR serves both directions; checks sit outside on the cipher side
  assign dataOut = inBit ^ (xorEn & ksHold_r);

  // Walker next state; slot attributes are caught on slotStart only
  always_comb begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    encOn_nxt = encOn_r;
    case (state_r)
      air_frame_keystream_xor_pkg::ST_IDLE: begin
        if (slotStart) begin
          state_nxt = air_frame_keystream_xor_pkg::ST_FIELD;
          pos_nxt   = `POS_RST;
          encOn_nxt = cipherOn;
        end
      end
      air_frame_keystream_xor_pkg::ST_FIELD: begin
        if (push && (pos_r == `FIELD_LAST)) begin
          state_nxt = air_frame_keystream_xor_pkg::ST_IDLE;
          pos_nxt   = `POS_RST;
        end else if (push) begin
          pos_nxt   = pos_r + 9'h001;
        end
      end
      default: begin
        state_nxt = air_frame_keystream_xor_pkg::ST_IDLE;
        pos_nxt   = `POS_RST;
      end
    endcase
  end

  // Keystream demand at the next position
  assign needNxt = encOn_nxt && (state_nxt == air_frame_keystream_xor_pkg::ST_FIELD)
                   && (isTail(pos_nxt) || isBData(pos_nxt));

  // Keystream holding stage: set by a take, cleared by use
  always_comb begin
    ksHeld_nxt = ksHeld_r;
    if (push && need) begin
      ksHeld_nxt = 1'b0;
    end
    if (ksTake) begin
      ksHeld_nxt = 1'b1;
    end
  end

  // Output buffer next state; a pop frees the head before a push refills
  always_comb begin
    headV_nxt = headV_r;
    headB_nxt = headB_r;
    skidV_nxt = skidV_r;
    skidB_nxt = skidB_r;
    if (pop) begin
      headV_nxt = skidV_r;
      headB_nxt = skidB_r;
      skidV_nxt = 1'b0;
    end
    if (push && !headV_nxt) begin
      headV_nxt = 1'b1;
      headB_nxt = dataOut;
    end else if (push) begin
      skidV_nxt = 1'b1;
      skidB_nxt = dataOut;
    end
  end

  // Walker registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= air_frame_keystream_xor_pkg::ST_IDLE;
      pos_r   <= `POS_RST;
      encOn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r   <= pos_nxt;
      encOn_r <= encOn_nxt;
    end
  end

  // Slot attributes, decoded by the framing logic from the header
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlTail_r <= 1'b0;
      prot_r    <= 1'b0;
    end else if ((state_r == air_frame_keystream_xor_pkg::ST_IDLE) && slotStart) begin
      ctlTail_r <= (tailType == air_frame_keystream_xor_pkg::TAIL_C);
      prot_r    <= protFmt;
    end
  end

  // Subblock offset: 64 data bits then 16 check bits, restarting each 80
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_r <= `SUB_RST;
    end else if (state_r == air_frame_keystream_xor_pkg::ST_IDLE) begin
      sub_r <= `SUB_RST;
    end else if (push && inBData && (sub_r == `SUB_LAST)) begin
      sub_r <= `SUB_RST;
    end else if (push && inBData) begin
      sub_r <= sub_r + 7'h01;
    end
  end

  // Keystream bit store
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ksHeld_r <= 1'b0;
      ksHold_r <= 1'b0;
    end else begin
      ksHeld_r <= ksHeld_nxt;
      if (ksTake) begin
        ksHold_r <= ksBit;
      end
    end
  end

  // Segment index and pair half; the generator restarts each frame, so
  // frameStart returns to the first segment. Fields in a frame come in
  // time order, which is the order the two segments are produced
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      segIdx_r    <= `SEG_RST;
      segSecond_r <= 1'b0;
    end else if (frameStart) begin
      segIdx_r    <= `SEG_RST;
      segSecond_r <= 1'b0;
    end else if (push && need && (segIdx_r == `SEG_LAST)) begin
      segIdx_r    <= `SEG_RST;
      segSecond_r <= !segSecond_r;
    end else if (push && need) begin
      segIdx_r    <= segIdx_r + 9'h001;
    end
  end

  // Output buffer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      headV_r <= 1'b0;
      headB_r <= 1'b0;
      skidV_r <= 1'b0;
      skidB_r <= 1'b0;
    end else begin
      headV_r <= headV_nxt;
      headB_r <= headB_nxt;
      skidV_r <= skidV_nxt;
      skidB_r <= skidB_nxt;
    end
  end

  // Registered readies: a field bit is taken only with room in the buffer
  // and, when it needs one, a keystream bit already held. Costs a cycle of
  // latency per keystream bit but keeps every port on a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inReady_r   <= 1'b0;
      ksReady_r   <= 1'b0;
      fieldBusy_r <= 1'b0;
    end else begin
      inReady_r   <= (state_nxt == air_frame_keystream_xor_pkg::ST_FIELD) && !skidV_nxt
                     && (!needNxt || ksHeld_nxt);
      ksReady_r   <= needNxt && !ksHeld_nxt;
      fieldBusy_r <= (state_nxt == air_frame_keystream_xor_pkg::ST_FIELD);
    end
  end

  // Ports
  assign inReady   = inReady_r;
  assign ksReady   = ksReady_r;
  assign outValid  = headV_r;
  assign outBit    = headB_r;
  assign fieldBusy = fieldBusy_r;
  assign segSecond = segSecond_r;

endmodule : air_frame_keystream_xor

// [inc/air_frame_keystream_xor_params.svh]
// Purpose: Field layout, keystream layout and reset values for the slot cipher
// Assumes: Bit positions count from the first bit of the slot field on the air
// Notes:   Definitions only; included by bare name
`ifndef AIR_FRAME_KEYSTREAM_XOR_PARAMS_SVH
`define AIR_FRAME_KEYSTREAM_XOR_PARAMS_SVH

// Slot field: A-field then B-field
`define FIELD_BITS      9'h184
`define A_BITS          9'h040
`define HDR_BITS        9'h008
`define TAIL_BITS       9'h028
`define CRC_A_BITS      9'h010
`define B_DATA_BITS     9'h140
`define B_CRC_BITS      9'h004

// Derived positions within the field
`define TAIL_FIRST      9'h008
`define TAIL_LAST       9'h02F
`define B_FIRST         9'h040
`define B_DATA_LAST     9'h17F
`define FIELD_LAST      9'h183

// Protected format: 64 data bits then a 16-bit check, four times
`define SUB_PERIOD      7'h50
`define SUB_DATA        7'h40
`define SUB_LAST        7'h4F

// Keystream segment: 360 bits, two per frame
`define SEG_BITS        9'h168
`define SEG_LAST        9'h167

// Reset values
`define POS_RST         9'h000
`define SUB_RST         7'h00
`define SEG_RST         9'h000

`endif

// [inc/air_frame_keystream_xor_pkg.sv]
// Purpose: Types shared by the slot cipher and its bench
// Assumes: Framing logic decodes the tail type from the A-field header
// Notes:   Constants live in air_frame_keystream_xor_params.svh
package air_frame_keystream_xor_pkg;

  // Tail types carried in the A-field
  typedef enum logic [2:0] {
    TAIL_P = 3'h0,
    TAIL_N = 3'h1,
    TAIL_Q = 3'h2,
    TAIL_M = 3'h3,
    TAIL_C = 3'h4
  } tail_t;

  // Field walker state
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_FIELD = 1'b1
  } walk_t;

endpackage : air_frame_keystream_xor_pkg

// [verif/air_frame_keystream_xor_monitor.sv]
// Purpose: Port checks for the slot keystream XOR
// Assumes: One clock domain, rst_n async active low
// Notes:   Field position is rebuilt from accepted input bits
`timescale 1ns/1ps
module air_frame_keystream_xor_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Slot control
  input wire logic slotStart,
  input wire logic cipherOn,
  input wire logic frameStart,
  // Handshakes
  input wire logic inValid,
  input wire logic inReady,
  input wire logic ksValid,
  input wire logic ksReady,
  input wire logic outValid,
  input wire logic outBit,
  input wire logic outReady,
  // Status
  input wire logic fieldBusy,
  input wire logic segSecond
);
  logic [8:0] pos_r;                        // Index of the next field bit
  logic [8:0] ksCnt_r;                      // Keystream bits taken in this field
  logic       on_r;                         // Cipher state latched at field open
  wire        open_w = slotStart && !fieldBusy;
  wire        last_w = fieldBusy && inValid && inReady && (pos_r == 9'h183);
  // Rebuild field position; slotStart inside a field is ignored by the block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r   <= 9'h000;
      ksCnt_r <= 9'h000;
      on_r    <= 1'b0;
    end else if (open_w) begin
      pos_r   <= 9'h000;
      ksCnt_r <= 9'h000;
      on_r    <= cipherOn;
    end else begin
      pos_r   <= pos_r + 9'((inValid && inReady) ? 1 : 0);
      ksCnt_r <= ksCnt_r + 9'((ksValid && ksReady) ? 1 : 0);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_idle_in; !fieldBusy |-> !inReady; endproperty
  a_idle_in: assert property (p_idle_in) else $error("inReady high while idle");
  property p_busy_start; open_w |=> fieldBusy; endproperty
  a_busy_start: assert property (p_busy_start) else $error("field did not open");
  property p_busy_end; last_w |=> !fieldBusy; endproperty
  a_busy_end: assert property (p_busy_end) else $error("field not 388 bits");
  property p_no_ks_clear;
    (!fieldBusy || pos_r < 9'h008 || (pos_r >= 9'h030 && pos_r < 9'h040) || pos_r >= 9'h180)
      |-> !ksReady;
  endproperty
  a_no_ks_clear: assert property (p_no_ks_clear) else $error("keystream on clear bit");
  property p_off_no_ks; !on_r |-> !ksReady; endproperty
  a_off_no_ks: assert property (p_off_no_ks) else $error("keystream used when off");
  property p_ks_count; last_w && on_r |-> ksCnt_r == 9'h168; endproperty
  a_ks_count: assert property (p_ks_count) else $error("segment not 360 bits");
  property p_ks_hold; fieldBusy && ksReady && !ksValid |=> ksReady; endproperty
  a_ks_hold: assert property (p_ks_hold) else $error("ksReady dropped early");
  property p_ks_take; ksValid && ksReady |=> !ksReady; endproperty
  a_ks_take: assert property (p_ks_take) else $error("second key bit held");
  property p_out_hold; outValid && !outReady |=> outValid && $stable(outBit); endproperty
  a_out_hold: assert property (p_out_hold) else $error("output lost in stall");
  property p_seg_clear; frameStart |=> !segSecond; endproperty
  a_seg_clear: assert property (p_seg_clear) else $error("segment index kept");
endmodule : air_frame_keystream_xor_monitor
bind air_frame_keystream_xor air_frame_keystream_xor_monitor i_air_frame_keystream_xor_monitor (
  .core_clk, .rst_n, .slotStart, .cipherOn, .frameStart, .inValid, .inReady,
  .ksValid, .ksReady, .outValid, .outBit, .outReady, .fieldBusy, .segSecond);

// [verif/air_frame_keystream_model.sv]
// Purpose: Keystream generator model for the slot cipher bench
// Assumes: Pattern bit k is a fixed function of the output count
// Notes:   Slow mode waits three cycles after every take
`timescale 1ns/1ps
module air_frame_keystream_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic frameStart,
  input  wire logic slowMode,
  // Keystream handshake
  input  wire logic ksReady,
  output logic      ksValid,
  output logic      ksBit
);
  logic [9:0] cnt_r;  // Bits issued since restart, 720 per frame
  logic [1:0] gap_r;  // Cycles since the last take, saturating
  function automatic logic pat(input logic [9:0] k);
    return k[0] ^ k[2] ^ k[5] ^ (k[3] & k[7]);
  endfunction : pat
  // Count restarts with each frame; bit 0 is the first one issued
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 10'h000;
      gap_r <= 2'h0;
    end else if (frameStart) begin
      cnt_r <= 10'h000;
    end else if (ksValid && ksReady) begin
      cnt_r <= cnt_r + 10'h001;
      gap_r <= 2'h0;
    end else if (gap_r != 2'h3) begin
      gap_r <= gap_r + 2'h1;
    end
  end
  // Valid holds until taken, since gap only clears on a take
  assign ksValid = !slowMode || (gap_r == 2'h3);
  // Without valid the line shows the inverse, so stale data cannot pass
  assign ksBit   = ksValid ? pat(cnt_r) : !pat(cnt_r);
endmodule : air_frame_keystream_model

// [verif/air_frame_keystream_xor_tb.sv]
// Purpose: Self-checking bench for the slot keystream XOR
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Expected keystream is rebuilt here from the model's count
`timescale 1ns/1ps
module air_frame_keystream_xor_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, slotStart = 1'b0, cipherOn = 1'b0;
  logic protFmt = 1'b0, frameStart = 1'b0, inValid = 1'b0, inBit = 1'b0;
  logic outReady = 1'b1, slowMode = 1'b0, stall = 1'b0;
  air_frame_keystream_xor_pkg::tail_t tailType = air_frame_keystream_xor_pkg::TAIL_P;
  logic ksValid, ksBit, inReady, ksReady, outValid, outBit, fieldBusy, segSecond;
  int   miscompares = 0, n_checks = 0, cyc = 0;
  logic din[388];   // Field bits to send
  logic q[$];       // Field bits received
  always #20 core_clk = ~core_clk;
  // Sink; when stalling it takes one bit in eight so the buffer fills
  always @(posedge core_clk) begin
    if (outValid === 1'b1 && outReady) q.push_back(outBit);
    cyc <= cyc + 1;
    outReady <= !stall || (cyc % 8 == 0);
  end
  air_frame_keystream_xor i_air_frame_keystream_xor (.core_clk(core_clk), .rst_n(rst_n),
    .slotStart(slotStart), .cipherOn(cipherOn), .tailType(tailType), .protFmt(protFmt),
    .frameStart(frameStart), .inValid(inValid), .inBit(inBit), .inReady(inReady),
    .ksValid(ksValid), .ksBit(ksBit), .ksReady(ksReady), .outValid(outValid),
    .outBit(outBit), .outReady(outReady), .fieldBusy(fieldBusy), .segSecond(segSecond));
  air_frame_keystream_model i_air_frame_keystream_model (.core_clk(core_clk), .rst_n(rst_n),
    .frameStart(frameStart), .slowMode(slowMode), .ksReady(ksReady), .ksValid(ksValid),
    .ksBit(ksBit));
  task automatic check(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : check
  function automatic logic kpat(input int k);
    logic [9:0] v;
    v = 10'(k);
    return v[0] ^ v[2] ^ v[5] ^ (v[3] & v[7]);
  endfunction : kpat
  // Keystream bit applied at field bit k, or 0 where the bit stays clear
  function automatic logic xk(input logic on, input air_frame_keystream_xor_pkg::tail_t tt,
                              input logic pr, input int base, input int k);
    if (!on) return 1'b0;
    if (k >= 8 && k < 48) begin
      return (tt == air_frame_keystream_xor_pkg::TAIL_C) && kpat(base + k - 8);
    end
    if (k < 64 || k >= 384) return 1'b0;
    if (pr && ((k - 64) % 80) >= 64) return 1'b0;
    return kpat(base + k - 24);
  endfunction : xk
  task automatic new_frame;
    @(posedge core_clk) frameStart <= 1'b1;
    @(posedge core_clk) frameStart <= 1'b0;
  endtask : new_frame
  // One field: open, send 388 bits, collect and compare every bit
  task automatic run_field(input logic on, input air_frame_keystream_xor_pkg::tail_t tt,
                           input logic pr, input int base);
    int w;
    q.delete();
    // Look one edge later so a frameStart on the last edge has settled
    @(posedge core_clk);
    if (on) check("segSecond", base != 0, segSecond);
    slotStart <= 1'b1;
    cipherOn <= on;
    tailType <= tt;
    protFmt <= pr;
    @(posedge core_clk) slotStart <= 1'b0;
    for (int k = 0; k < 388; k++) begin
      inValid <= 1'b1;
      inBit <= din[k];
      w = 0;
      do begin
        @(posedge core_clk);
        w++;
      end while (inReady !== 1'b1 && w < 200);
      check("inAccept", 1'b1, inReady);
    end
    inValid <= 1'b0;
    w = 0;
    while (q.size() < 388 && w < 2000) begin
      @(posedge core_clk);
      w++;
    end
    check("fieldBusy", 1'b0, fieldBusy);
    check("outCount", 1'b1, q.size() == 388);
    for (int k = 0; k < 388 && k < q.size(); k++) begin
      check("outBit", din[k] ^ xk(on, tt, pr, base, k), q[k]);
    end
  endtask : run_field
  task automatic sc_clear;
    run_field(1'b0, air_frame_keystream_xor_pkg::TAIL_C, 1'b0, 0);
  endtask : sc_clear
  task automatic sc_stall_pair;
    slowMode <= 1'b1;
    stall <= 1'b1;
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_C, 1'b0, 0);
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_N, 1'b1, 360);
    slowMode <= 1'b0;
    stall <= 1'b0;
  endtask : sc_stall_pair
  task automatic sc_tail_types;
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_P, 1'b1, 0);
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_Q, 1'b0, 0);
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_M, 1'b1, 0);
  endtask : sc_tail_types
  // Ciphertext sent again with the same segment must give the clear bits back
  task automatic sc_round_trip;
    logic orig[388];
    orig = din;
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_C, 1'b1, 0);
    foreach (din[k]) din[k] = q[k];
    new_frame();
    run_field(1'b1, air_frame_keystream_xor_pkg::TAIL_C, 1'b1, 0);
    foreach (orig[k]) check("roundTrip", orig[k], q[k]);
  endtask : sc_round_trip
  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // Watchdog: the run needs well under 40000 cycles
  initial begin
    #(40 * 60000);
    miscompares++;
    finish_test();
  end
  initial begin
    foreach (din[k]) din[k] = k[0] ^ k[3] ^ (k[1] & k[6]);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check("resetBusy", 1'b0, fieldBusy);
    sc_clear();
    sc_stall_pair();
    sc_tail_types();
    sc_round_trip();
    finish_test();
  end
endmodule : air_frame_keystream_xor_tb
